// file: hdl/jlc_pkg.sv
// Constants for the link error, lane and constant-output configuration block
package jlc_pkg;
    localparam int   ADDR_W    = 12;
    localparam int   DATA_W    = 8;
    localparam int   LANES     = 8;
    localparam int   CNT_W     = 8;
    // Register offsets
    localparam logic [11:0] OFF_SYNC_MASK   = 12'h47b;
    localparam logic [11:0] OFF_THRESHOLD   = 12'h47c;
    localparam logic [11:0] OFF_LANE_EN     = 12'h47d;
    localparam logic [11:0] OFF_RAMP_CHECK  = 12'h47e;
    localparam logic [11:0] OFF_TEST_CTRL   = 12'h520;
    localparam logic [11:0] OFF_VALUE_LOW   = 12'h521;
    localparam logic [11:0] OFF_VALUE_HIGH  = 12'h522;
    localparam logic [11:0] OFF_IRQ_STATUS  = 12'h530;
    localparam logic [11:0] OFF_IRQ_MASK    = 12'h531;
    localparam logic [11:0] OFF_LANE_STATUS = 12'h532;
    localparam logic [11:0] OFF_CNT_CLEAR   = 12'h533;
    // Reset values
    localparam logic [7:0] RST_THRESHOLD  = 8'hff;
    localparam logic [7:0] RST_LANE_EN    = 8'h0f;
    localparam logic [7:0] RST_SYNC_MASK  = 8'h08;
    localparam logic [7:0] RST_TEST_CTRL  = 8'h1c;
    localparam logic [7:0] RST_ZERO       = 8'h00;
    // Field positions
    localparam int BIT_SYNC_BADDISP  = 7;
    localparam int BIT_SYNC_NOTABLE  = 6;
    localparam int BIT_SYNC_UNEXPCTL = 5;
    localparam int BIT_MISMATCH_FLAG = 4;
    localparam int BIT_MISMATCH_EN   = 3;
    localparam int BIT_CONST_TEST    = 1;
    localparam int BIT_RAMP_EN       = 0;
    localparam int BIT_IRQ_BADDISP   = 0;
    localparam int BIT_IRQ_NOTABLE   = 1;
    localparam int BIT_IRQ_UNEXPCTL  = 2;
    localparam int BIT_IRQ_MISMATCH  = 3;
    localparam int BIT_IRQ_RAMPFAIL  = 4;
    localparam int IRQ_W             = 5;
    // Ramp check states
    typedef enum logic [3:0] {
        RAMP_IDLE  = 4'b0001,
        RAMP_WAIT1 = 4'b0010,
        RAMP_WAIT2 = 4'b0100,
        RAMP_DONE  = 4'b1000
    } jlc_ramp_type;
    localparam logic [7:0] RAMP_FIRST  = 8'h00;
    localparam logic [7:0] RAMP_SECOND = 8'h01;
    localparam logic [7:0] RAMP_THIRD  = 8'h02;
endpackage : jlc_pkg

// file: hdl/jlc_err_counter.sv
// Saturating per-lane error counter with threshold compare
module jlc_err_counter #(
    parameter int CNT_W = 8
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             enable,
    input  wire logic             clear,
    input  wire logic             errorPulse,
    input  wire logic [CNT_W-1:0] threshold,
    output logic                  reached
);
    logic [CNT_W-1:0] count_reg;

    if (CNT_W < 1) begin : gBadWidth
        $error("CNT_W must be positive");
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
        end else if (clear || !enable) begin
            count_reg <= '0;
        end else if (errorPulse && count_reg != '1) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign reached = enable && (count_reg >= threshold);
endmodule : jlc_err_counter

// file: hdl/jlc_ramp_check.sv
// Initial lane alignment ramp checker for one lane
module jlc_ramp_check (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       checkEnable,
    input  wire logic       alignStart,
    input  wire logic       dataValid,
    input  wire logic [7:0] alignData,
    output logic            rampFail,
    output logic            rampPass
);
    jlc_pkg::jlc_ramp_type state_reg;
    logic                  fail_reg;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= jlc_pkg::RAMP_IDLE;
            fail_reg  <= 1'b0;
        end else if (alignStart) begin
            fail_reg  <= 1'b0;
            state_reg <= jlc_pkg::RAMP_IDLE;
        end else if (dataValid) begin
            case (state_reg)
                jlc_pkg::RAMP_IDLE: begin
                    // Only record while checking, so enabling later
                    // never revives a stale failure
                    fail_reg  <= checkEnable &&
                                 alignData != jlc_pkg::RAMP_FIRST;
                    state_reg <= jlc_pkg::RAMP_WAIT1;
                end
                jlc_pkg::RAMP_WAIT1: begin
                    if (checkEnable && alignData != jlc_pkg::RAMP_SECOND)
                        fail_reg <= 1'b1;
                    state_reg <= jlc_pkg::RAMP_WAIT2;
                end
                jlc_pkg::RAMP_WAIT2: begin
                    if (checkEnable && alignData != jlc_pkg::RAMP_THIRD)
                        fail_reg <= 1'b1;
                    state_reg <= jlc_pkg::RAMP_DONE;
                end
                jlc_pkg::RAMP_DONE: state_reg <= jlc_pkg::RAMP_DONE;
                default: state_reg <= jlc_pkg::RAMP_IDLE;
            endcase
        end
    end

    // Disabled check accepts any content
    assign rampFail = checkEnable && fail_reg;
    assign rampPass = (state_reg == jlc_pkg::RAMP_DONE) && !rampFail;
endmodule : jlc_ramp_check

// file: hdl/jlc_link_config.sv
// Link error threshold, lane enable, ramp check and constant output block
// Operation
// - Mismatch interrupt enable clear blocks mismatch interrupts; resets to 1.
// - With mismatch interrupt enable set, a mismatch raises an interrupt.
// - Three error kinds count apart against an 8-bit threshold, reset 0xff.
// - A count at threshold raises an interrupt, a sync request or both.
// - Every enabled lane counts and compares alike against one shared threshold; disabled lanes hold zero.
// - An 8-bit lane enable field, bit x for lane x, resets to lanes 0 to 3.
// - With ramp check clear (its reset state) alignment data is not checked.
// - Ramp check set: alignment data must be 00, 01, 02 or start-up fails.
// - Constant test gives both converters a 16-bit value from two registers.
module jlc_link_config #(
    parameter int LANES = jlc_pkg::LANES,
    parameter int CNT_W = jlc_pkg::CNT_W
) (
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic [11:0]          regAddr,
    input  wire logic [7:0]           regWdata,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    output logic      [7:0]           regRdata,
    input  wire logic [LANES-1:0]     badDisparity,
    input  wire logic [LANES-1:0]     notInTable,
    input  wire logic [LANES-1:0]     unexpectedControl,
    input  wire logic                 configMismatch,
    input  wire logic                 alignStart,
    input  wire logic [LANES-1:0]     alignValid,
    input  wire logic [LANES*8-1:0]   alignData,
    input  wire logic [15:0]          sampleData0,
    input  wire logic [15:0]          sampleData1,
    output logic      [LANES-1:0]     laneActive,
    output logic      [LANES-1:0]     syncRequestOut,
    output logic                      rampFailed,
    output logic                      startupAllowed,
    output logic      [15:0]          dacData0,
    output logic      [15:0]          dacData1,
    output logic                      irq
);
    localparam int IRQ_WL = jlc_pkg::IRQ_W;

    logic [7:0]       threshold_reg;
    logic [7:0]       link_lane_enable_reg;
    logic [7:0]       syncMask_reg;
    logic             rampEnable_reg;
    logic [7:0]       testCtrl_reg;
    logic [7:0]       valueLow_reg;
    logic [7:0]       valueHigh_reg;
    logic [IRQ_WL-1:0] irqStatus_reg;
    logic [IRQ_WL-1:0] irqMask_reg;
    logic             counterClear_reg;
    logic             mismatchPrev_reg;
    logic             mismatchFlag_reg;
    logic [7:0]       regRdata_next;
    logic [LANES-1:0] hitBad;
    logic [LANES-1:0] hitNit;
    logic [LANES-1:0] hitUcc;
    logic [LANES-1:0] laneRampFail;
    logic [LANES-1:0] laneRampPass;
    logic [IRQ_WL-1:0] irqEvents;
    logic             mismatchRise;
    logic             wrSync;

    if (LANES < 1 || LANES > 8) begin : gBadLanes
        $error("LANES must be 1 to 8");
    end
    if (CNT_W != 8) begin : gBadWidth
        $error("CNT_W must match the 8-bit threshold");
    end

    // Per-lane counters share one threshold
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gLane
            jlc_err_counter #(.CNT_W(CNT_W)) uBad (
                .clock      (clock),
                .nrst       (nrst),
                .enable     (link_lane_enable_reg[g]),
                .clear      (counterClear_reg),
                .errorPulse (badDisparity[g]),
                .threshold  (threshold_reg),
                .reached    (hitBad[g])
            );
            jlc_err_counter #(.CNT_W(CNT_W)) uNit (
                .clock      (clock),
                .nrst       (nrst),
                .enable     (link_lane_enable_reg[g]),
                .clear      (counterClear_reg),
                .errorPulse (notInTable[g]),
                .threshold  (threshold_reg),
                .reached    (hitNit[g])
            );
            jlc_err_counter #(.CNT_W(CNT_W)) uUcc (
                .clock      (clock),
                .nrst       (nrst),
                .enable     (link_lane_enable_reg[g]),
                .clear      (counterClear_reg),
                .errorPulse (unexpectedControl[g]),
                .threshold  (threshold_reg),
                .reached    (hitUcc[g])
            );
            jlc_ramp_check uRamp (
                .clock       (clock),
                .nrst        (nrst),
                .checkEnable (rampEnable_reg),
                .alignStart  (alignStart),
                .dataValid   (alignValid[g] && link_lane_enable_reg[g]),
                .alignData   (alignData[g*8 +: 8]),
                .rampFail    (laneRampFail[g]),
                .rampPass    (laneRampPass[g])
            );
        end
    endgenerate

    assign laneActive = link_lane_enable_reg[LANES-1:0];
    assign wrSync = regWrite && regAddr == jlc_pkg::OFF_SYNC_MASK;

    // Sync request per lane, gated by the sync masks
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            syncRequestOut <= '0;
        end else begin
            syncRequestOut <=
                (hitBad & {LANES{syncMask_reg[jlc_pkg::BIT_SYNC_BADDISP]}})
              | (hitNit & {LANES{syncMask_reg[jlc_pkg::BIT_SYNC_NOTABLE]}})
              | (hitUcc & {LANES{syncMask_reg[jlc_pkg::BIT_SYNC_UNEXPCTL]}});
        end
    end

    // Ramp result; a failed lane blocks start-up
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rampFailed     <= 1'b0;
            startupAllowed <= 1'b0;
        end else begin
            rampFailed     <= |laneRampFail;
            startupAllowed <= !(|laneRampFail) &&
                ((laneRampPass & link_lane_enable_reg[LANES-1:0]) ==
                 link_lane_enable_reg[LANES-1:0]);
        end
    end

    // Mismatch edge only latches while enabled
    assign mismatchRise = configMismatch && !mismatchPrev_reg;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mismatchPrev_reg <= 1'b0;
            mismatchFlag_reg <= 1'b0;
        end else begin
            mismatchPrev_reg <= configMismatch;
            if (mismatchRise && syncMask_reg[jlc_pkg::BIT_MISMATCH_EN]) begin
                mismatchFlag_reg <= 1'b1;
            end else if (wrSync && regWdata[jlc_pkg::BIT_MISMATCH_FLAG]) begin
                mismatchFlag_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        irqEvents = '0;
        irqEvents[jlc_pkg::BIT_IRQ_BADDISP]  = |hitBad;
        irqEvents[jlc_pkg::BIT_IRQ_NOTABLE]  = |hitNit;
        irqEvents[jlc_pkg::BIT_IRQ_UNEXPCTL] = |hitUcc;
        irqEvents[jlc_pkg::BIT_IRQ_MISMATCH] =
            mismatchRise && syncMask_reg[jlc_pkg::BIT_MISMATCH_EN];
        irqEvents[jlc_pkg::BIT_IRQ_RAMPFAIL] = |laneRampFail;
    end

    // Sticky status; a new event beats a write-one clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irqStatus_reg <= '0;
        end else if (regWrite && regAddr == jlc_pkg::OFF_IRQ_STATUS) begin
            irqStatus_reg <= (irqStatus_reg & ~regWdata[IRQ_WL-1:0])
                           | irqEvents;
        end else begin
            irqStatus_reg <= irqStatus_reg | irqEvents;
        end
    end

    assign irq = |(irqStatus_reg & irqMask_reg);

    // Software registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            threshold_reg  <= jlc_pkg::RST_THRESHOLD;
            link_lane_enable_reg <= jlc_pkg::RST_LANE_EN;
            syncMask_reg   <= jlc_pkg::RST_SYNC_MASK;
            rampEnable_reg <= 1'b0;
            testCtrl_reg   <= jlc_pkg::RST_TEST_CTRL;
            valueLow_reg   <= jlc_pkg::RST_ZERO;
            valueHigh_reg  <= jlc_pkg::RST_ZERO;
            irqMask_reg    <= '0;
        end else if (regWrite) begin
            case (regAddr)
                jlc_pkg::OFF_THRESHOLD:  threshold_reg  <= regWdata;
                jlc_pkg::OFF_LANE_EN:    link_lane_enable_reg <= regWdata;
                jlc_pkg::OFF_SYNC_MASK:  syncMask_reg   <= regWdata & 8'he8;
                jlc_pkg::OFF_RAMP_CHECK:
                    rampEnable_reg <= regWdata[jlc_pkg::BIT_RAMP_EN];
                // Upper bits stored as written; software keeps defaults
                jlc_pkg::OFF_TEST_CTRL:  testCtrl_reg   <= regWdata;
                jlc_pkg::OFF_VALUE_LOW:  valueLow_reg   <= regWdata;
                jlc_pkg::OFF_VALUE_HIGH: valueHigh_reg  <= regWdata;
                jlc_pkg::OFF_IRQ_MASK:
                    irqMask_reg <= regWdata[IRQ_WL-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            counterClear_reg <= 1'b0;
        end else begin
            counterClear_reg <= regWrite &&
                regAddr == jlc_pkg::OFF_CNT_CLEAR && regWdata[0];
        end
    end

    // Constant test replaces samples on both converters
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dacData0 <= '0;
            dacData1 <= '0;
        end else if (testCtrl_reg[jlc_pkg::BIT_CONST_TEST]) begin
            dacData0 <= {valueHigh_reg, valueLow_reg};
            dacData1 <= {valueHigh_reg, valueLow_reg};
        end else begin
            dacData0 <= sampleData0;
            dacData1 <= sampleData1;
        end
    end

    // Read mux; unmapped reads give zero
    always_comb begin
        regRdata_next = '0;
        case (regAddr)
            jlc_pkg::OFF_SYNC_MASK: begin
                regRdata_next = syncMask_reg;
                regRdata_next[jlc_pkg::BIT_MISMATCH_FLAG] = mismatchFlag_reg;
            end
            jlc_pkg::OFF_THRESHOLD:  regRdata_next = threshold_reg;
            jlc_pkg::OFF_LANE_EN:    regRdata_next = link_lane_enable_reg;
            jlc_pkg::OFF_RAMP_CHECK: regRdata_next = {7'h00, rampEnable_reg};
            jlc_pkg::OFF_TEST_CTRL:  regRdata_next = testCtrl_reg;
            jlc_pkg::OFF_VALUE_LOW:  regRdata_next = valueLow_reg;
            jlc_pkg::OFF_VALUE_HIGH: regRdata_next = valueHigh_reg;
            jlc_pkg::OFF_IRQ_STATUS:
                regRdata_next[IRQ_WL-1:0] = irqStatus_reg;
            jlc_pkg::OFF_IRQ_MASK:
                regRdata_next[IRQ_WL-1:0] = irqMask_reg;
            jlc_pkg::OFF_LANE_STATUS:
                regRdata_next[LANES-1:0] = hitBad | hitNit | hitUcc;
            default: regRdata_next = '0;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            regRdata <= '0;
        end else if (regRead) begin
            regRdata <= regRdata_next;
        end else begin
            regRdata <= '0;
        end
    end
endmodule : jlc_link_config

// file: tb/jlc_link_config_sva.sv
// Port assertions for the link configuration block
module jlc_link_config_sva #(
    parameter int LANES = 8
) (
    input wire logic             clock,
    input wire logic             nrst,
    input wire logic [11:0]      regAddr,
    input wire logic [7:0]       regWdata,
    input wire logic             regWrite,
    input wire logic             regRead,
    input wire logic [7:0]       regRdata,
    input wire logic [LANES-1:0] badDisparity,
    input wire logic [LANES-1:0] notInTable,
    input wire logic [LANES-1:0] unexpectedControl,
    input wire logic [15:0]      sampleData0,
    input wire logic [15:0]      sampleData1,
    input wire logic [LANES-1:0] laneActive,
    input wire logic [LANES-1:0] syncRequestOut,
    input wire logic             rampFailed,
    input wire logic             startupAllowed,
    input wire logic [15:0]      dacData0,
    input wire logic [15:0]      dacData1
);
    logic       constMode;
    logic [7:0] valueLow;
    logic [7:0] valueHigh;
    logic       cause0;
    assign cause0 = badDisparity[0] | notInTable[0] | unexpectedControl[0];
    // Shadow only what the converter path needs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            constMode <= 1'b0;
            valueLow  <= 8'h00;
            valueHigh <= 8'h00;
        end else if (regWrite) begin
            if (regAddr == jlc_pkg::OFF_TEST_CTRL) begin
                constMode <= regWdata[jlc_pkg::BIT_CONST_TEST];
            end
            if (regAddr == jlc_pkg::OFF_VALUE_LOW) begin
                valueLow <= regWdata;
            end
            if (regAddr == jlc_pkg::OFF_VALUE_HIGH) begin
                valueHigh <= regWdata;
            end
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    chk_read_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
        else $error("read data not idle");
    chk_unmapped_read: assert property ($past(regRead)
        && $past(regAddr) == 12'h400 |-> regRdata == 8'h00)
        else $error("unmapped read not zero");
    chk_lane_reset: assert property ($rose(nrst)
        |-> laneActive == 8'h0f)
        else $error("lane enable reset wrong");
    chk_sync_cause: assert property ($rose(syncRequestOut[0])
        |-> $past(cause0 | regWrite) || $past(cause0 | regWrite, 2))
        else $error("sync request without cause");
    chk_sync_hold: assert property ($past(syncRequestOut[0])
        && !$past(regWrite) && !$past(regWrite, 2) |-> syncRequestOut[0])
        else $error("sync request dropped");
    chk_dac_normal: assert property (!$past(constMode)
        |-> dacData0 == $past(sampleData0) && dacData1 == $past(sampleData1))
        else $error("converter data not samples");
    chk_dac_const: assert property ($past(constMode)
        |-> dacData0 == {$past(valueHigh), $past(valueLow)}
        && dacData1 == dacData0)
        else $error("converter data not constant");
    chk_start_fail: assert property (rampFailed |-> !startupAllowed)
        else $error("start-up despite ramp failure");
endmodule : jlc_link_config_sva

bind jlc_link_config jlc_link_config_sva #(.LANES(LANES)) u_sva (
    .clock(clock), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .badDisparity(badDisparity), .notInTable(notInTable),
    .unexpectedControl(unexpectedControl), .sampleData0(sampleData0),
    .sampleData1(sampleData1), .laneActive(laneActive),
    .syncRequestOut(syncRequestOut), .rampFailed(rampFailed),
    .startupAllowed(startupAllowed), .dacData0(dacData0), .dacData1(dacData1));

// file: tb/jlc_tx_model.sv
// Transmitter model sending the alignment start and three bytes per lane
module jlc_tx_model (
    input  wire logic clock,
    output logic        alignStart,
    output logic [7:0]  alignValid,
    output logic [63:0] alignData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        alignStart = 1'b0;
        alignValid = 8'h00;
        alignData  = 64'h0;
    end
    // Idle gaps invert the data so stale bytes never look valid
    task automatic ilas(input logic good, input int gap);
        @(posedge clock);
        alignStart <= 1'b1;
        @(posedge clock);
        alignStart <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (gap > 0) begin
                alignValid <= 8'h00;
                alignData  <= ~alignData;
                repeat (gap) @(posedge clock);
            end
            alignValid <= 8'hff;
            alignData  <= {8{good ? 8'(i) : 8'(i + 5)}};
            @(posedge clock);
        end
        alignValid <= 8'h00;
        alignData  <= ~alignData;
    endtask : ilas
endmodule : jlc_tx_model

// file: tb/tb.sv
// Self-checking bench for the link configuration block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, nrst, regWrite, regRead, configMismatch, alignStart;
    logic [11:0] regAddr;
    logic [7:0]  regWdata, regRdata, badDisparity, notInTable, thr, lo, hi;
    logic [7:0]  unexpectedControl, alignValid, laneActive, syncRequestOut;
    logic [63:0] alignData;
    logic [15:0] sampleData0, sampleData1, dacData0, dacData1;
    logic        rampFailed, startupAllowed, irq, rdTaken, run;
    logic [7:0]  expQ[$];
    int          err_total, checked, seed, lane;
    logic [11:0] ra [8] = '{12'h47c, 12'h47d, 12'h47e, 12'h520, 12'h521,
                            12'h522, 12'h47b, 12'h400};
    logic [7:0]  rv [8] = '{8'hff, 8'h0f, 8'h00, 8'h1c, 8'h00, 8'h00,
                            8'h08, 8'h00};
    jlc_link_config uut (.clock(clock), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .badDisparity(badDisparity),
        .notInTable(notInTable), .unexpectedControl(unexpectedControl),
        .configMismatch(configMismatch), .alignStart(alignStart),
        .alignValid(alignValid), .alignData(alignData),
        .sampleData0(sampleData0), .sampleData1(sampleData1),
        .laneActive(laneActive), .syncRequestOut(syncRequestOut),
        .rampFailed(rampFailed), .startupAllowed(startupAllowed),
        .dacData0(dacData0), .dacData1(dacData1), .irq(irq));
    jlc_tx_model tx (.clock(clock), .alignStart(alignStart),
        .alignValid(alignValid), .alignData(alignData));
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clock);
        {regAddr, regRead} <= {a, 1'b1};
        expQ.push_back(e);
        @(posedge clock);
        regRead <= 1'b0;
    endtask : rd
    task automatic pulse(input int k, input int l, input int n);
        @(posedge clock);
        badDisparity      <= (k == 0) ? 8'h01 << l : 8'h00;
        notInTable        <= (k == 1) ? 8'h01 << l : 8'h00;
        unexpectedControl <= (k == 2) ? 8'h01 << l : 8'h00;
        repeat (n) @(posedge clock);
        {badDisparity, notInTable, unexpectedControl} <= 24'h0;
        @(posedge clock);
    endtask : pulse
    task automatic mismatch;
        @(posedge clock);
        configMismatch <= 1'b1;
        repeat (3) @(posedge clock);
        configMismatch <= 1'b0;
        @(negedge clock);
    endtask : mismatch
    task automatic results;
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Read data belong to the strobe seen one edge earlier
    always @(posedge clock) rdTaken = regRead;
    always @(negedge clock) begin
        if (rdTaken === 1'b1) begin
            chk("regRdata", {8'h00, expQ.pop_front()}, {8'h00, regRdata});
        end
    end
    always @(posedge clock) begin
        if (run === 1'b1) begin
            sampleData0 <= 16'($random(seed));
            sampleData1 <= 16'($random(seed));
        end
    end
    initial begin
        #300000;
        err_total++;
        results();
    end
    initial begin
        seed = 75708;
        {nrst, regWrite, regRead, configMismatch, run, regAddr} = '0;
        {regWdata, badDisparity, notInTable, unexpectedControl} = '0;
        {sampleData0, sampleData1, err_total, checked} = '0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        chk("laneActive", 16'h000f, laneActive);
        for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
        lo = 8'($random(seed));
        wr(12'h47d, lo);
        @(negedge clock);
        chk("laneActive", {8'h00, lo}, laneActive);
        rd(12'h47d, lo);
        wr(12'h47d, 8'hff);
        run <= 1'b1;
        wr(12'h47b, 8'he8);
        wr(12'h531, 8'h1f);
        for (int k = 0; k < 3; k++) begin
            lane = k * 3;
            thr = 8'(($random(seed) & 7) + 2);
            wr(12'h47c, thr);
            rd(12'h47c, thr);
            pulse(k, lane, int'(thr) - 1);
            @(negedge clock);
            chk("syncRequestOut", 16'h0000, syncRequestOut);
            chk("irq", 16'h0000, irq);
            pulse(k, lane, 1);
            @(negedge clock);
            chk("syncRequestOut", 16'h0001 << lane, syncRequestOut);
            chk("irq", 16'h0001, irq);
            rd(12'h530, 8'h01 << k);
            rd(12'h532, 8'h01 << lane);
            wr(12'h47d, ~(8'h01 << lane));
            pulse(k, lane, int'(thr));
            @(negedge clock);
            chk("syncRequestOut", 16'h0000, syncRequestOut);
            wr(12'h47d, 8'hff);
            wr(12'h533, 8'h01);
            wr(12'h530, 8'h1f);
        end
        wr(12'h47c, 8'hff);
        pulse(0, 0, 258);
        @(negedge clock);
        chk("syncRequestOut", 16'h0001, syncRequestOut);
        wr(12'h533, 8'h01);
        wr(12'h530, 8'h1f);
        wr(12'h47b, 8'he0);
        mismatch();
        chk("irq", 16'h0000, irq);
        wr(12'h47b, 8'he8);
        mismatch();
        chk("irq", 16'h0001, irq);
        rd(12'h47b, 8'hf8);
        wr(12'h530, 8'h1f);
        wr(12'h47b, 8'hf8);
        rd(12'h47b, 8'he8);
        tx.ilas(1'b0, 0);
        repeat (2) @(negedge clock);
        chk("rampFailed", 16'h0000, rampFailed);
        chk("startupAllowed", 16'h0001, startupAllowed);
        wr(12'h47e, 8'h01);
        repeat (2) @(negedge clock);
        chk("rampFailed", 16'h0000, rampFailed);
        tx.ilas(1'b1, 2);
        repeat (2) @(negedge clock);
        chk("startupAllowed", 16'h0001, startupAllowed);
        tx.ilas(1'b0, 0);
        repeat (2) @(negedge clock);
        chk("rampFailed", 16'h0001, rampFailed);
        chk("startupAllowed", 16'h0000, startupAllowed);
        rd(12'h530, 8'h10);
        wr(12'h47e, 8'h00);
        lo = 8'($random(seed));
        hi = 8'($random(seed));
        wr(12'h521, lo);
        wr(12'h522, hi);
        wr(12'h520, 8'h1e);
        repeat (2) @(negedge clock);
        chk("dacData0", {hi, lo}, dacData0);
        chk("dacData1", {hi, lo}, dacData1);
        rd(12'h520, 8'h1e);
        wr(12'h520, 8'h1c);
        repeat (2) @(negedge clock);
        results();
    end
endmodule : tb
